// File: logic/aps_sequencer.sv
// aps_sequencer.sv: address sequencing and pass control for array passes
// assumes a single 50 MHz clock and synchronous strobes from the system
//
// Functional notes
// - single memory interleaves reads and writes
// - single port halves rate, doubles pass
// - collect, process passes, then dump sequence when single memory, not cascaded
// - reads left memory, writes right memory
// - left and right neighbour node registers
// - swap memory allocation at every pass end
// - cascade node repeats one instruction
// - window sequential or symmetric addressing
// - pass lasts N or 2N memory cycles
// - fixed overhead cycles added per pass
// - split pass refused in single memory
// - odd power: radix-2 then mixed radix-4
// - split places frames in upper, lower halves
// - write sequence delayed behind read sequence
`include "aps_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module aps_sequencer #(
   parameter int AW = 10,               // log2 of array size N
   parameter int OVH = `APS_PASS_OVERHEAD,
   parameter int WD = `APS_WR_DELAY
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,            // begin process, with collect/dump when single memory, not cascaded
   input wire logic single_mem_i,       // single memory recursive mode
   input wire logic cascade_i,          // cascaded node
   input wire logic digit_rev_i,        // dump in digit-reversed order
   input wire logic odd_pow_i,          // N is an odd power of two
   input wire logic [3:0] npass_i,      // processing passes per frame
   input wire aps_pkg::aps_instr_t instr_i,
   input wire aps_pkg::aps_node_t left_type_i,
   input wire aps_pkg::aps_node_t right_type_i,
   input wire logic cfg_we_i,           // load neighbour registers
   output aps_pkg::aps_bus_t bus_first_o,
   output aps_pkg::aps_bus_t bus_left_o,
   output aps_pkg::aps_bus_t bus_right_o,
   output logic [15:0] coef_addr_o,
   output aps_pkg::aps_func_t func_o,
   output logic mixed_o,
   output logic half_rate_o,
   output logic alloc_o,
   output logic split_err_o,
   output logic busy_o,
   output logic pass_done_o
);
   import aps_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_COLLECT = 5'b00010,
      S_PASS = 5'b00100,
      S_DUMP = 5'b01000,
      S_DONE = 5'b10000
   } aps_state_t;

   localparam int CW = AW + 7;
   localparam logic [CW-1:0] N = CW'(1 << AW);

   // ------------------------------------------------------------
   // state and counters
   // ------------------------------------------------------------
   aps_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;        // memory cycle counter
   logic phase, next_phase;             // 0 read slot, 1 write slot
   logic [3:0] pass, next_pass;
   logic alloc, next_alloc;
   logic err, next_err;
   logic done, next_done;
   aps_node_t left_type, next_left_type, right_type, next_right_type;
   aps_bus_t bf, next_bf, bl, next_bl, br, next_br;
   logic [15:0] caddr, next_caddr;
   aps_func_t func, next_func;
   logic mixed, next_mixed;
   logic [CW-1:0] len;
   logic [AW-1:0] ra, wa, rev, sw;
   logic wr_live;

   // digit reversal over base-4 digits, radix-2 leftover at top
   always_comb begin
      rev = '0;
      for (int i = 0; i < AW / 2; i++) begin
         rev[AW-1-2*i -: 2] = cnt[2*i +: 2];
      end
      if (AW % 2 == 1) begin
         rev[0] = cnt[AW-1];
      end
   end

   // read index and delayed write index
   always_comb begin
      ra = cnt[AW-1:0];
      wa = AW'(cnt - CW'(WD));
      wr_live = (cnt >= CW'(WD)) && (cnt < N + CW'(WD));
      len = N + CW'(OVH);
      // split pass: first/second frame to lower/upper half
      sw = (instr_i.func == APS_FN_SPLIT) ?
         {wa[0], wa[AW-1:1]} : wa;
   end

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_phase = phase;
      next_pass = pass;
      next_alloc = alloc;
      next_err = err;
      next_done = 1'b0;
      next_left_type = cfg_we_i ? left_type_i : left_type;
      next_right_type = cfg_we_i ? right_type_i : right_type;
      next_bf = '0;
      next_bl = '0;
      next_br = '0;
      next_caddr = caddr;
      next_func = func;
      next_mixed = mixed;
      unique case (state)
         S_IDLE: begin
            next_cnt = '0;
            next_phase = 1'b0;
            next_pass = '0;
            if (start_i) begin
               // refuse a split run before any collect on the bus
               if (single_mem_i && instr_i.func == APS_FN_SPLIT) begin
                  next_err = 1'b1;
               end else begin
                  next_err = 1'b0;
                  next_state = (single_mem_i && !cascade_i) ?
                     S_COLLECT : S_PASS;
               end
            end
         end
         S_COLLECT: begin
            next_bf = '{addr: 16'(ra), rd: 1'b0, wr: 1'b1};
            next_cnt = cnt + 1'b1;
            if (cnt == N - 1'b1) begin
               next_cnt = '0;
               next_state = S_PASS;
            end
         end
         S_PASS: begin
            // pass function: cascade repeats instr, else schedule
            next_func = instr_i.func;
            next_mixed = instr_i.mixed;
            if (!cascade_i && odd_pow_i && instr_i.func == APS_FN_BF4) begin
               next_func = (pass == 4'h0) ? APS_FN_BF2 : APS_FN_BF4;
               next_mixed = (pass != 4'h0);
            end
            if (single_mem_i && instr_i.func == APS_FN_SPLIT) begin
               next_err = 1'b1;
               next_state = S_IDLE;
            end else begin
               // window coefficient address
               if (instr_i.win_sym && ra[AW-1]) begin
                  next_caddr = 16'(~ra);
               end else begin
                  next_caddr = 16'(ra);
               end
               if (single_mem_i) begin
                  // alternate read and write slots
                  next_phase = ~phase;
                  if (!phase && cnt < N) begin
                     next_bf = '{addr: 16'(ra), rd: 1'b1, wr: 1'b0};
                  end else if (phase && wr_live) begin
                     next_bf = '{addr: 16'(wa), rd: 1'b0, wr: 1'b1};
                  end
               end else begin
                  if (alloc) begin
                     // reallocated: read right, write left
                     if (cnt < N) next_br = '{16'(ra), 1'b1, 1'b0};
                     if (wr_live) next_bl = '{16'(sw), 1'b0, 1'b1};
                  end else begin
                     if (cnt < N) next_bl = '{16'(ra), 1'b1, 1'b0};
                     if (wr_live) next_br = '{16'(sw), 1'b0, 1'b1};
                  end
               end
               if (!single_mem_i || phase) begin
                  next_cnt = cnt + 1'b1;
               end
               if ((!single_mem_i || phase) && cnt == len - 1'b1) begin
                  next_cnt = '0;
                  next_phase = 1'b0;
                  next_done = 1'b1;
                  next_alloc = ~alloc;
                  next_pass = pass + 1'b1;
                  if (cascade_i) begin
                     next_state = S_DONE;
                  end else if (pass + 1'b1 >= npass_i) begin
                     next_state = single_mem_i ? S_DUMP : S_DONE;
                  end
               end
            end
         end
         S_DUMP: begin
            next_bf = '{addr: 16'(digit_rev_i ? rev : ra),
                        rd: 1'b1, wr: 1'b0};
            next_cnt = cnt + 1'b1;
            if (cnt == N - 1'b1) begin
               next_cnt = '0;
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         cnt <= '0;
         phase <= 1'b0;
         pass <= '0;
         alloc <= 1'b0;
         err <= 1'b0;
         done <= 1'b0;
         left_type <= APS_NODE_NONE;
         right_type <= APS_NODE_NONE;
         bf <= '0;
         bl <= '0;
         br <= '0;
         caddr <= '0;
         func <= APS_FN_MUL;
         mixed <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         phase <= next_phase;
         pass <= next_pass;
         alloc <= next_alloc;
         err <= next_err;
         done <= next_done;
         left_type <= next_left_type;
         right_type <= next_right_type;
         bf <= next_bf;
         bl <= next_bl;
         br <= next_br;
         caddr <= next_caddr;
         func <= next_func;
         mixed <= next_mixed;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // shared buses stay quiet when the neighbour slot is absent in a cascaded node
   assign bus_first_o = bf;
   assign bus_left_o = (left_type == APS_NODE_NONE && cascade_i) ? '0 : bl;
   assign bus_right_o = (right_type == APS_NODE_NONE && cascade_i) ? '0 : br;
   assign coef_addr_o = caddr;
   assign func_o = func;
   assign mixed_o = mixed;
   assign half_rate_o = single_mem_i;
   assign alloc_o = alloc;
   assign split_err_o = err;
   assign busy_o = (state != S_IDLE);
   assign pass_done_o = done;
endmodule // aps_sequencer
`default_nettype wire

// File: include/aps_defs.svh
// aps_defs.svh: timing counts and mode codes for the pass sequencer
// assumes inclusion by bare name from the sequencer design file
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH
`define APS_PASS_OVERHEAD 24
`define APS_MEM_CYCLE_NS 20
`define APS_CLK_PERIOD_NS 20
`define APS_CYC_PER_MEM (`APS_MEM_CYCLE_NS / `APS_CLK_PERIOD_NS)
`define APS_WR_DELAY 8
`define APS_MODE_RECURSIVE 1'b0
`define APS_MODE_CASCADE 1'b1
`endif

// File: include/aps_pkg.sv
// aps_pkg.sv: types for the array pass address sequencer
// assumes aps_defs.svh is on the include path
package aps_pkg;
   typedef enum logic [2:0] {
      APS_FN_MUL = 3'h0,   // block multiply (window or filter)
      APS_FN_BF2 = 3'h1,   // radix-2 butterfly
      APS_FN_BF4 = 3'h2,   // radix-4 butterfly
      APS_FN_MSQ = 3'h3,   // magnitude square
      APS_FN_SPLIT = 3'h4  // real split
   } aps_func_t;

   // one pass instruction
   typedef struct packed {
      aps_func_t func;
      logic mixed;         // radix-4 pass in mixed-radix mode
      logic win_sym;       // symmetric window addressing
   } aps_instr_t;

   // address bus word with its strobes
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
   } aps_bus_t;

   // neighbour node type, one per side
   typedef enum logic [1:0] {
      APS_NODE_NONE = 2'h0,
      APS_NODE_INPUT = 2'h1,
      APS_NODE_PROC = 2'h2,
      APS_NODE_OUTPUT = 2'h3
   } aps_node_t;
endpackage

// File: dv/aps_sequencer_asserts.sv
// aps_sequencer_asserts.sv: port-level checks for the pass sequencer
// assumes binding to aps_sequencer with its AW and OVH
`timescale 1ns/100ps
`default_nettype none
module aps_sequencer_asserts #(
   parameter int AW = 10,
   parameter int OVH = 24
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic single_mem_i,
   input wire aps_pkg::aps_instr_t instr_i,
   input wire aps_pkg::aps_bus_t bus_first_o,
   input wire aps_pkg::aps_bus_t bus_left_o,
   input wire aps_pkg::aps_bus_t bus_right_o,
   input wire logic half_rate_o,
   input wire logic alloc_o,
   input wire logic split_err_o,
   input wire logic busy_o,
   input wire logic pass_done_o
);
   import aps_pkg::*;
   localparam int PL = (1 << AW) + OVH;
   logic [15:0] gap;
   logic seen;
   logic any_rd;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   assign any_rd = bus_left_o.rd | bus_right_o.rd;
   // cycles since the last pass end within one run
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap <= 16'h0;
         seen <= 1'b0;
      end else begin
         gap <= pass_done_o ? 16'h0 : gap + 16'h1;
         seen <= busy_o & (seen | pass_done_o);
      end
   end
   sequence s_taken;
      start_i && !busy_o && !(single_mem_i && instr_i.func == APS_FN_SPLIT);
   endsequence
   sequence s_dual_wr;
      !single_mem_i && (bus_left_o.wr || bus_right_o.wr);
   endsequence
   property p_start; s_taken |=> busy_o [*2]; endproperty
   property p_lag; s_dual_wr |-> $past(any_rd, 8); endproperty
   property p_len;
      pass_done_o && seen |-> gap == (single_mem_i ? 2 * PL : PL) - 1;
   endproperty
   property p_alloc; pass_done_o |-> ##[0:1] $changed(alloc_o); endproperty
   property p_done; pass_done_o |=> !pass_done_o; endproperty
   property p_rate; half_rate_o == single_mem_i; endproperty
   property p_excl; !(bus_first_o.rd && bus_first_o.wr); endproperty
   property p_split; split_err_o |-> !bus_first_o.rd && !bus_first_o.wr;
   endproperty
   a_start: assert property (p_start) else $error("start lost");
   a_lag: assert property (p_lag) else $error("write lag");
   a_len: assert property (p_len) else $error("pass length");
   a_alloc: assert property (p_alloc) else $error("no swap");
   a_done: assert property (p_done) else $error("long done");
   a_rate: assert property (p_rate) else $error("rate");
   a_excl: assert property (p_excl) else $error("rd with wr");
   a_split: assert property (p_split) else $error("split bus");
endmodule // aps_sequencer_asserts
`default_nettype wire

// File: dv/aps_mem_model.sv
// aps_mem_model.sv: data memory side, pairs each write with the oldest pending read, if any
// assumes registered strobes on three packed buses, cleared by start
`timescale 1ns/100ps
`default_nettype none
module aps_mem_model (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic [53:0] b_i,
   output var int rd_o,
   output var int wr_o,
   output var int bad_o
);
   import aps_pkg::*;
   logic [15:0] rq[$];
   aps_bus_t x;
   // a write must land where its element was read, oldest first
   always @(posedge clk_i) begin
      if (clr_i) begin
         rq.delete();
         rd_o = 0;
         wr_o = 0;
         bad_o = 0;
      end
      for (int k = 2; k >= 0; k--) begin
         x = b_i[18*k +: 18];
         if (x.wr) begin
            wr_o++;
            if (rq.size() > 0 && rq.pop_front() !== x.addr)
               bad_o++;
         end
         if (x.rd) begin
            rd_o++;
            rq.push_back(x.addr);
         end
      end
   end
endmodule // aps_mem_model
`default_nettype wire

// File: dv/aps_sequencer_test.sv
// aps_sequencer_test.sv: self-checking bench for the pass sequencer
// assumes package, checker and memory model compiled before it
`timescale 1ns/100ps
`default_nettype none
module aps_sequencer_test;
   import aps_pkg::*;
   localparam int N = 16;
   logic clk_i, rst_i, start_i, single_mem_i, cascade_i, digit_rev_i;
   logic odd_pow_i, cfg_we_i, mixed_o, half_rate_o, alloc_o;
   logic split_err_o, busy_o, pass_done_o;
   logic [3:0] npass_i;
   logic [15:0] coef_addr_o;
   logic [31:0] seed;
   aps_instr_t instr_i;
   aps_node_t left_type_i, right_type_i;
   aps_bus_t bus_first_o, bus_left_o, bus_right_o;
   aps_func_t func_o;
   aps_func_t fq[$];
   int failures, checked, passes, rd_n, wr_n, bad_n, lb, np;
   aps_sequencer #(.AW(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .start_i(start_i), .single_mem_i(single_mem_i),
      .cascade_i(cascade_i), .digit_rev_i(digit_rev_i),
      .odd_pow_i(odd_pow_i), .npass_i(npass_i), .instr_i(instr_i),
      .left_type_i(left_type_i), .right_type_i(right_type_i),
      .cfg_we_i(cfg_we_i), .bus_first_o(bus_first_o),
      .bus_left_o(bus_left_o), .bus_right_o(bus_right_o),
      .coef_addr_o(coef_addr_o), .func_o(func_o), .mixed_o(mixed_o),
      .half_rate_o(half_rate_o), .alloc_o(alloc_o),
      .split_err_o(split_err_o), .busy_o(busy_o),
      .pass_done_o(pass_done_o));
   aps_mem_model mem_u (.clk_i(clk_i), .clr_i(start_i),
      .b_i({bus_first_o, bus_left_o, bus_right_o}), .rd_o(rd_n),
      .wr_o(wr_n), .bad_o(bad_n));
   // xorshift source for random inputs
   function automatic logic [31:0] nxt(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one run from start to idle, then counts against the model
   task automatic run(input logic sm, cs, od, input aps_func_t fn,
         input int n, input int ep, input int en, input int ew);
      int t;
      logic a0;
      logic [15:0] ca;
      seed = nxt(seed);
      {single_mem_i, cascade_i, odd_pow_i, npass_i} = {sm, cs, od, 4'(n)};
      instr_i = '{fn, 1'b0, seed[0]};
      digit_rev_i = seed[1];
      a0 = alloc_o;
      start_i = 1'b1;
      @(posedge clk_i) #2;
      start_i = 1'b0;
      {passes, lb} = '0;
      fq.delete();
      for (t = 0; t < 3000; t++) begin
         if (pass_done_o === 1'b1) begin
            passes++;
            fq.push_back(func_o);
         end
         if (bus_left_o !== 18'h0)
            lb++;
         // window address follows the read index, mirrored when symmetric
         if (fn == APS_FN_MUL && (bus_left_o.rd || bus_right_o.rd)) begin
            ca = bus_left_o.rd ? bus_left_o.addr : bus_right_o.addr;
            if (instr_i.win_sym && ca >= 16'(N / 2))
               ca = 16'(N - 1) - ca;
            chk(coef_addr_o, ca);
         end
         if (busy_o === 1'b0 && t > 3)
            break;
         @(posedge clk_i) #2;
      end
      if (t == 3000) begin
         failures++;
         print_verdict();
      end
      chk(half_rate_o, sm);
      chk(passes, ep);
      chk(rd_n, en);
      chk(wr_n, ew);
      chk(bad_n, 0);
      chk(alloc_o, a0 ^ passes[0]);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // main sequence
   initial begin
      {start_i, single_mem_i, cascade_i, digit_rev_i, odd_pow_i} = '0;
      {cfg_we_i, npass_i, instr_i, failures, checked} = '0;
      left_type_i = APS_NODE_PROC;
      right_type_i = APS_NODE_PROC;
      seed = 32'hD4CAFA29;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      #2 rst_i = 1'b0;
      cfg_we_i = 1'b1;
      @(posedge clk_i) #2;
      cfg_we_i = 1'b0;
      for (int f = 0; f < 4; f++) begin
         seed = nxt(seed);
         np = seed[1:0] % 3 + 1;
         run(0, 0, 0, aps_func_t'(f), np, np, np * N, np * N);
      end
      run(1, 0, 0, APS_FN_BF4, np, np, np * N + N, np * N + N);
      run(1, 0, 0, APS_FN_SPLIT, 2, 0, 0, 0);
      chk(split_err_o, 1);
      run(0, 0, 1, APS_FN_BF4, 2, 2, 2 * N, 2 * N);
      chk(split_err_o, 0);
      chk(fq[0], APS_FN_BF2);
      chk(fq[1], APS_FN_BF4);
      chk(mixed_o, 1);
      repeat (2) begin
         run(0, 1, 0, APS_FN_BF4, 1, 1, N, N);
         chk(fq[0], APS_FN_BF4);
      end
      // one more pass if needed so the next pass is the reallocated one
      if (alloc_o == 1'b0)
         run(0, 1, 0, APS_FN_BF4, 1, 1, N, N);
      left_type_i = APS_NODE_NONE;
      cfg_we_i = 1'b1;
      @(posedge clk_i) #2;
      cfg_we_i = 1'b0;
      // reads go right and stay visible, writes to the absent left are held
      run(0, 1, 0, APS_FN_MUL, 1, 1, N, 0);
      chk(lb, 0);
      print_verdict();
   end
endmodule // aps_sequencer_test
bind aps_sequencer aps_sequencer_asserts #(.AW(AW), .OVH(OVH)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .instr_i(instr_i),
   .single_mem_i(single_mem_i), .bus_first_o(bus_first_o),
   .bus_left_o(bus_left_o), .bus_right_o(bus_right_o),
   .half_rate_o(half_rate_o), .alloc_o(alloc_o), .busy_o(busy_o),
   .split_err_o(split_err_o), .pass_done_o(pass_done_o));
`default_nettype wire
